// ### eiac_cpu_model.sv
// Behavioural CPU core: instruction boundaries and program counter
`timescale 1ns/1ps
module eiac_cpu_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] instr_len,
    output logic instr_last_clk,
    output logic [15:0] pc_in
);
    logic [3:0] cnt_q;

    // Instructions of instr_len clocks (1 to 15), PC advances at each end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h1;
            pc_in <= 16'h1234;
        end else if (cnt_q >= instr_len) begin
            cnt_q <= 4'h1;
            pc_in <= pc_in + 16'h0102;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    assign instr_last_clk = (cnt_q >= instr_len);
endmodule

// ### eiac_edge_det.sv
// Two-stage synchroniser and selectable edge detector for one pin
`timescale 1ns/1ps
module eiac_edge_det
    import eiac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    output logic pin_sync,
    output logic edge_hit
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [2:0] fill_q;
    logic edge_raw;

    // Synchronise then remember last level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            fill_q <= 3'h0;
        end else begin
            fill_q <= {fill_q[1:0], 1'b1};
            meta_q <= pin; // RQ26
            sync_q <= meta_q; // RQ26
            prev_q <= sync_q;
        end
    end

    assign pin_sync = sync_q;

    // Edge qualification per select code
    always_comb begin
        case (eiac_edge_e'(edge_sel))
            EIAC_EDGE_FALL: edge_raw = prev_q & ~sync_q; // RQ1
            EIAC_EDGE_RISE: edge_raw = ~prev_q & sync_q; // RQ1
            EIAC_EDGE_BOTH: edge_raw = prev_q ^ sync_q; // RQ1
            default: edge_raw = 1'b0; // RQ1
        endcase
    end

    // Reset levels are not pin samples: no false edge right after reset
    assign edge_hit = edge_raw & fill_q[2];
endmodule

// ### eiac_map.svh
// Register offsets, field positions, reset values and timing counts
// Operation
// (RQ1) Edge select: 00 fall, 01 rise, 11 both
// (RQ2) Select A: pin2 7:6, pin1 5:4, pin0 3:2
// (RQ3) Select B: comparator 7:6, pin3 1:0
// (RQ4) Software masks, clears request, then unmasks
// (RQ5) Status word holds global enable, resets 02h
// (RQ6) Acknowledge pushes status, clears global enable
// (RQ7) Key select: bit0 group, bits 4,5 single
// (RQ8) Selected key pin falling edge raises request
// (RQ9) Selected key pin gets pull-up unless output
// (RQ10) Detect falling edge of AND of selected
// (RQ11) Software masks key source around select write
// (RQ12) Non-maskable ignores enable, beats all maskable
// (RQ13) Non-maskable pushes status, PC, vectors
// (RQ14) Non-maskable nests inside its own routine
// (RQ15) Maskable needs request, no mask, enable
// (RQ16) Request to service takes 9 to 19 clocks
// (RQ17) Highest priority eligible request goes first
// (RQ18) Pending request taken once conditions hold
// (RQ19) Maskable pushes status, PC, loads own vector
// (RQ20) Flag in final clock waits one instruction
// (RQ21) Hold requests while flag registers accessed
// (RQ22) Maskable nesting only after enable re-set
// (RQ23) Priority 0 highest through 15 lowest
// (RQ24) Request set on event, cleared on acknowledge
// (RQ25) Masks reset to ones, requests to zero
// (RQ26) Pins synchronised by two flip-flops first
`ifndef EIAC_MAP_SVH
`define EIAC_MAP_SVH
`define EIAC_ADDR_SEL_A 16'hFFEC
`define EIAC_ADDR_SEL_B 16'hFFED
`define EIAC_ADDR_KEY_SEL 16'hFFF5
`define EIAC_RST_SEL 8'h00
`define EIAC_RST_PSW 8'h02
`define EIAC_RST_MASK 16'hFFFF
`define EIAC_RST_REQ 16'h0000
`define EIAC_PSW_IE_BIT 1
`define EIAC_SEL_A_WMASK 8'hFC
`define EIAC_SEL_B_WMASK 8'hC3
`define EIAC_KEY_WMASK 8'h31
`define EIAC_SRC_PIN0 1
`define EIAC_SRC_PIN1 2
`define EIAC_SRC_PIN2 3
`define EIAC_SRC_PIN3 4
`define EIAC_SRC_KEY 13
`define EIAC_SRC_CMP 15
`define EIAC_LAT_MIN_CLK 9
`define EIAC_LAT_MAX_CLK 19
`endif

// ### eiac_pkg.sv
// Types shared by the interrupt front end
package eiac_pkg;
    typedef enum logic [1:0] {
        EIAC_EDGE_FALL = 2'b00,
        EIAC_EDGE_RISE = 2'b01,
        EIAC_EDGE_BAD = 2'b10,
        EIAC_EDGE_BOTH = 2'b11
    } eiac_edge_e;
    typedef enum logic [1:0] {
        EIAC_ST_IDLE = 2'b00,
        EIAC_ST_PUSH_PSW = 2'b01,
        EIAC_ST_PUSH_PC = 2'b10,
        EIAC_ST_VECTOR = 2'b11
    } eiac_state_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } eiac_sfr_s;
    typedef struct packed {
        logic start;
        logic nmi;
        logic [3:0] source;
    } eiac_ack_s;
endpackage

// ### eiac_properties.sv
// Concurrent checks on request gating and the acknowledge sequence
`timescale 1ns/1ps
module eiac_chk
    import eiac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic instr_last_clk,
    input wire logic flag_reg_access,
    input wire logic [7:0] program_status_word,
    input wire logic global_irq_enable,
    input wire logic [15:0] source_request_flag,
    input wire logic [15:0] source_mask_flag,
    input wire eiac_ack_s ack,
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr
);
    // All checks live in the CPU clock domain
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    chk_ack_clears_ie: assert property (
        ack.start |=> !global_irq_enable)
        else $error("enable still set after acknowledge");
    chk_status_push: assert property (
        ack.start |=> ##1 push_valid &&
        push_data == $past(program_status_word, 2))
        else $error("status word not pushed first");
    chk_vector_time: assert property (
        ack.start |-> ##5 vector_valid)
        else $error("vector not issued five cycles after acknowledge");
    chk_nmi_vector: assert property (
        ack.start && ack.nmi |-> ##5 vector_addr == 16'h0004)
        else $error("wrong non-maskable vector");
    chk_gate_maskable: assert property (
        ack.start && !ack.nmi |-> global_irq_enable &&
        source_request_flag[ack.source] && !source_mask_flag[ack.source])
        else $error("maskable acknowledge without its conditions");
    chk_priority_order: assert property (
        ack.start && !ack.nmi |-> (source_request_flag & ~source_mask_flag &
        ((16'h0001 << ack.source) - 16'h0001)) == 16'h0000)
        else $error("higher priority source was skipped");
    chk_access_hold: assert property (
        flag_reg_access |-> !ack.start)
        else $error("acknowledge during flag register access");
    chk_final_clock: assert property (
        ack.start |-> instr_last_clk)
        else $error("acknowledge outside an instruction end");
    chk_req_cleared: assert property (
        ack.start && !ack.nmi |=> !source_request_flag[$past(ack.source)])
        else $error("request flag not cleared on acknowledge");
endmodule

bind eiac_top eiac_chk i_chk (
    .clk_sys, .reset_n, .instr_last_clk, .flag_reg_access,
    .program_status_word, .global_irq_enable, .source_request_flag,
    .source_mask_flag, .ack, .push_valid, .push_data, .vector_valid,
    .vector_addr
);

// ### eiac_top.sv
// Interrupt edge select, key return detect, request gating and acknowledge
`timescale 1ns/1ps
`include "eiac_map.svh"
module eiac_top
    import eiac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire eiac_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    input wire logic [3:0] ext_irq_pin,
    input wire logic comparator_irq,
    input wire logic [5:0] key_pin,
    input wire logic [5:0] key_pin_is_output,
    output logic [5:0] key_pullup_en,
    input wire logic [15:0] periph_req,
    input wire logic nmi_req,
    input wire logic instr_last_clk,
    input wire logic flag_reg_access,
    input wire logic enable_irq_instr,
    input wire logic irq_off_instr,
    input wire logic return_from_irq_instr,
    input wire logic psw_wr,
    input wire logic [7:0] psw_wdata,
    input wire logic mask_wr,
    input wire logic [15:0] mask_wdata,
    input wire logic req_clr,
    input wire logic [15:0] req_clr_bits,
    input wire logic [15:0] pc_in,
    output logic [7:0] program_status_word,
    output logic global_irq_enable,
    output logic [15:0] source_request_flag,
    output logic [15:0] source_mask_flag,
    output eiac_ack_s ack,
    output logic push_valid,
    output logic [7:0] push_data,
    output logic vector_valid,
    output logic [15:0] vector_addr
);
    logic [7:0] ext_edge_select_a_q;
    logic [7:0] ext_edge_select_b_q;
    logic [7:0] key_return_select_q;
    logic [7:0] psw_q;
    logic [15:0] mask_q;
    logic [15:0] req_q;
    logic [15:0] req_set;
    logic [4:0] sync_lvl;
    logic [4:0] edge_hit;
    logic [5:0] key_meta_q;
    logic [5:0] key_sync_q;
    logic key_and_prev_q;
    logic [5:0] key_en;
    logic key_and;
    logic key_fall;
    logic [15:0] eligible;
    logic mask_any;
    logic [3:0] win_src;
    logic arm_q;
    logic nmi_meta_q;
    logic nmi_sync_q;
    logic nmi_prev_q;
    logic nmi_pend_q;
    eiac_state_e state_q;
    logic take_nmi_q;
    logic [3:0] src_q;
    logic [7:0] psw_save_q;
    logic [15:0] pc_save_q;
    logic [1:0] pc_byte_q;
    logic [7:0] rdata_q;
    logic push_valid_q;
    logic [7:0] push_data_q;
    logic vector_valid_q;
    logic [15:0] vector_q;
    logic ack_start;

    // Lowest-numbered set bit wins
    function automatic logic [3:0] eiac_prio(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Vector address per source, two bytes per entry from the non-maskable 0004h, source 0 sharing it
    function automatic logic [15:0] eiac_vec(input logic [4:0] n);
        return 16'h0004 + {10'h000, n, 1'b0};
    endfunction

    // Edge detectors for four external pins and comparator
    for (genvar g = 0; g < 5; g++) begin : g_edge
        logic [1:0] sel;
        logic pin_in;
        if (g < 3) begin : g_a
            assign sel = ext_edge_select_a_q[2*g+3 -: 2]; // RQ2
            assign pin_in = ext_irq_pin[g];
        end else if (g == 3) begin : g_b
            assign sel = ext_edge_select_b_q[1:0]; // RQ3
            assign pin_in = ext_irq_pin[3];
        end else begin : g_c
            assign sel = ext_edge_select_b_q[7:6]; // RQ3
            assign pin_in = comparator_irq;
        end
        eiac_edge_det u_det (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .pin(pin_in),
            .edge_sel(sel),
            .pin_sync(sync_lvl[g]),
            .edge_hit(edge_hit[g])
        );
    end

    // Key pin synchronisers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_meta_q <= 6'h3F;
            key_sync_q <= 6'h3F;
        end else begin
            key_meta_q <= key_pin; // RQ26
            key_sync_q <= key_meta_q; // RQ26
        end
    end

    // Enabled key pins and falling edge of their AND
    assign key_en = {key_return_select_q[5:4], {4{key_return_select_q[0]}}};
    assign key_and = &(key_sync_q | ~key_en); // RQ10
    assign key_fall = key_and_prev_q & ~key_and & (|key_en); // RQ8
    assign key_pullup_en = key_en & ~key_pin_is_output; // RQ9

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_and_prev_q <= 1'b1;
        end else begin
            key_and_prev_q <= key_and;
        end
    end

    // Register writes on the documented special function addresses
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ext_edge_select_a_q <= `EIAC_RST_SEL; // RQ2
            ext_edge_select_b_q <= `EIAC_RST_SEL; // RQ3
            key_return_select_q <= `EIAC_RST_SEL; // RQ7
        end else if (sfr.wr) begin
            if (sfr.addr == `EIAC_ADDR_SEL_A) begin
                ext_edge_select_a_q <= sfr.wdata & `EIAC_SEL_A_WMASK; // RQ2
            end else if (sfr.addr == `EIAC_ADDR_SEL_B) begin
                ext_edge_select_b_q <= sfr.wdata & `EIAC_SEL_B_WMASK; // RQ3
            end else if (sfr.addr == `EIAC_ADDR_KEY_SEL) begin
                key_return_select_q <= sfr.wdata & `EIAC_KEY_WMASK; // RQ7
            end
        end
    end

    // Read data, zero for addresses not in this block
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (sfr.rd) begin
            if (sfr.addr == `EIAC_ADDR_SEL_A) begin
                rdata_q <= ext_edge_select_a_q;
            end else if (sfr.addr == `EIAC_ADDR_SEL_B) begin
                rdata_q <= ext_edge_select_b_q;
            end else if (sfr.addr == `EIAC_ADDR_KEY_SEL) begin
                rdata_q <= key_return_select_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end
    assign sfr_rdata = rdata_q;

    // Request sources mapped onto priority slots
    always_comb begin
        req_set = periph_req;
        req_set[`EIAC_SRC_PIN0] = edge_hit[0];
        req_set[`EIAC_SRC_PIN1] = edge_hit[1];
        req_set[`EIAC_SRC_PIN2] = edge_hit[2];
        req_set[`EIAC_SRC_PIN3] = edge_hit[3];
        req_set[`EIAC_SRC_KEY] = key_fall;
        req_set[`EIAC_SRC_CMP] = edge_hit[4];
    end

    // Request flags: set beats software clear and acknowledge clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= `EIAC_RST_REQ; // RQ25
        end else begin
            req_q <= (req_q
                & ~(req_clr ? req_clr_bits : 16'h0000)
                & ~((ack_start && !take_nmi_next()) ?
                    (16'h0001 << win_src) : 16'h0000)) // RQ24
                | req_set; // RQ24
        end
    end

    // Mask flags, all sources masked after reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= `EIAC_RST_MASK; // RQ25
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    // Eligibility and fixed priority select
    assign eligible = req_q & ~mask_q & {16{psw_q[`EIAC_PSW_IE_BIT]}}; // RQ15
    assign mask_any = |eligible;
    assign win_src = eiac_prio(eligible); // RQ17 RQ23

    // Non-maskable request sync and latch until taken
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nmi_meta_q <= 1'b0;
            nmi_sync_q <= 1'b0;
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_meta_q <= nmi_req;
            nmi_sync_q <= nmi_meta_q;
            nmi_prev_q <= nmi_sync_q;
            if (nmi_sync_q && !nmi_prev_q) begin
                nmi_pend_q <= 1'b1; // RQ14
            end else if (ack_start && nmi_pend_q) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    function automatic logic take_nmi_next();
        return nmi_pend_q; // RQ12
    endfunction

    // Arm on the clock before the last: a flag seen then is taken at end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arm_q <= 1'b0;
        end else begin
            arm_q <= (nmi_pend_q || mask_any) && !flag_reg_access; // RQ20 RQ21
        end
    end

    // Acknowledge at an instruction boundary, in idle only
    assign ack_start = (state_q == EIAC_ST_IDLE) && instr_last_clk
        && arm_q && !flag_reg_access // RQ18 RQ21
        && (nmi_pend_q || mask_any); // RQ16

    // Acknowledge sequencer: push status, push PC, vector
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= EIAC_ST_IDLE;
            take_nmi_q <= 1'b0;
            src_q <= 4'h0;
            psw_save_q <= 8'h00;
            pc_save_q <= 16'h0000;
            pc_byte_q <= 2'b00;
        end else begin
            case (state_q)
                EIAC_ST_IDLE: begin
                    if (ack_start) begin
                        take_nmi_q <= nmi_pend_q; // RQ12
                        src_q <= win_src;
                        psw_save_q <= psw_q; // RQ6
                        pc_save_q <= pc_in;
                        state_q <= EIAC_ST_PUSH_PSW;
                    end
                end
                EIAC_ST_PUSH_PSW: begin
                    pc_byte_q <= 2'b00;
                    state_q <= EIAC_ST_PUSH_PC; // RQ13 RQ19
                end
                EIAC_ST_PUSH_PC: begin
                    pc_byte_q <= pc_byte_q + 2'b01;
                    if (pc_byte_q == 2'b01) begin
                        state_q <= EIAC_ST_VECTOR;
                    end
                end
                EIAC_ST_VECTOR: begin
                    state_q <= EIAC_ST_IDLE;
                end
                default: begin
                    state_q <= EIAC_ST_IDLE;
                end
            endcase
        end
    end

    // Status word: instructions, whole-byte writes, cleared enable on acknowledge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            psw_q <= `EIAC_RST_PSW; // RQ5
        end else if (ack_start) begin
            psw_q[`EIAC_PSW_IE_BIT] <= 1'b0; // RQ6 RQ13 RQ19 RQ22
        end else if (psw_wr) begin
            psw_q <= psw_wdata; // RQ5
        end else if (enable_irq_instr) begin
            psw_q[`EIAC_PSW_IE_BIT] <= 1'b1; // RQ5 RQ22
        end else if (irq_off_instr) begin
            psw_q[`EIAC_PSW_IE_BIT] <= 1'b0; // RQ5
        end
    end

    // Stack push stream and vector load
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            push_valid_q <= 1'b0;
            push_data_q <= 8'h00;
            vector_valid_q <= 1'b0;
            vector_q <= 16'h0000;
        end else begin
            push_valid_q <= 1'b0;
            vector_valid_q <= 1'b0;
            case (state_q)
                EIAC_ST_PUSH_PSW: begin
                    push_valid_q <= 1'b1;
                    push_data_q <= psw_save_q; // RQ13 RQ19
                end
                EIAC_ST_PUSH_PC: begin
                    push_valid_q <= 1'b1;
                    push_data_q <= pc_byte_q[0] ? pc_save_q[7:0]
                        : pc_save_q[15:8];
                end
                EIAC_ST_VECTOR: begin
                    vector_valid_q <= 1'b1;
                    vector_q <= take_nmi_q ? 16'h0004
                        : eiac_vec({1'b0, src_q}); // RQ19
                end
                default: begin
                    push_valid_q <= 1'b0;
                end
            endcase
        end
    end

    // Outputs
    assign ack.start = ack_start;
    assign ack.nmi = nmi_pend_q;
    assign ack.source = win_src;
    assign push_valid = push_valid_q;
    assign push_data = push_data_q;
    assign vector_valid = vector_valid_q;
    assign vector_addr = vector_q;
    assign program_status_word = psw_q;
    assign global_irq_enable = psw_q[`EIAC_PSW_IE_BIT];
    assign source_request_flag = req_q;
    assign source_mask_flag = mask_q;
    // return_from_irq_instr is unused here; status is restored only by a psw_wr of the popped byte
    logic unused_return_from_irq_instr;
    assign unused_return_from_irq_instr = return_from_irq_instr;
endmodule

// ### tb_top.sv
// Self-checking bench for the interrupt front end
`timescale 1ns/1ps
module tb_top
    import eiac_pkg::*;
();
    logic clk_sys, reset_n, comparator_irq, nmi_req, instr_last_clk;
    logic flag_reg_access, enable_irq_instr, irq_off_instr, push_valid;
    logic return_from_irq_instr, psw_wr, mask_wr, req_clr, vector_valid;
    logic global_irq_enable;
    logic [3:0] ext_irq_pin, instr_len;
    logic [5:0] key_pin, key_pin_is_output, key_pullup_en;
    logic [7:0] sfr_rdata, psw_wdata, program_status_word, push_data;
    logic [15:0] periph_req, mask_wdata, req_clr_bits, pc_in, vector_addr;
    logic [15:0] source_request_flag, source_mask_flag;
    logic [1:0] code;
    eiac_sfr_s sfr;
    eiac_ack_s ack;
    int bad_count = 0;
    int tests_run = 0;
    int lat;

    eiac_top i_dut (
        .clk_sys, .reset_n, .sfr, .sfr_rdata, .ext_irq_pin, .comparator_irq,
        .key_pin, .key_pin_is_output, .key_pullup_en, .periph_req, .nmi_req,
        .instr_last_clk, .flag_reg_access, .enable_irq_instr, .irq_off_instr,
        .return_from_irq_instr, .psw_wr, .psw_wdata, .mask_wr, .mask_wdata,
        .req_clr, .req_clr_bits, .pc_in, .program_status_word,
        .global_irq_enable, .source_request_flag, .source_mask_flag, .ack,
        .push_valid, .push_data, .vector_valid, .vector_addr
    );
    eiac_cpu_model i_cpu (
        .clk_sys, .reset_n, .instr_len, .instr_last_clk, .pc_in
    );

    // Free-running CPU clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic sfr_op(input logic w, input logic [15:0] a,
        input logic [7:0] d);
        @(negedge clk_sys);
        sfr = {w, ~w, a, d};
        @(negedge clk_sys);
        sfr = '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        sfr_op(1'h0, a, 8'h00);
        chk("read data", {8'h00, e}, {8'h00, sfr_rdata});
    endtask
    task automatic set_mask(input logic [15:0] m);
        @(negedge clk_sys);
        mask_wr = 1'h1;
        mask_wdata = m;
        @(negedge clk_sys);
        mask_wr = 1'h0;
    endtask
    task automatic clr_req(input logic [15:0] m);
        @(negedge clk_sys);
        req_clr = 1'h1;
        req_clr_bits = m;
        @(negedge clk_sys);
        req_clr = 1'h0;
    endtask
    task automatic pulse_req(input logic [15:0] m);
        @(negedge clk_sys);
        periph_req = m;
        @(negedge clk_sys);
        periph_req = 16'h0000;
    endtask
    task automatic pulse_ie(input logic on);
        @(negedge clk_sys);
        enable_irq_instr = on;
        irq_off_instr = ~on;
        @(negedge clk_sys);
        {enable_irq_instr, irq_off_instr} = 2'h0;
    endtask
    // Waits for an acknowledge, then follows pushes and vector
    task automatic take_ack(input logic nmi, input logic [3:0] s,
        input logic [15:0] v, input logic [7:0] st);
        logic [15:0] pc;
        lat = 0;
        while (ack.start !== 1'h1 && lat < 100) begin
            @(negedge clk_sys);
            lat++;
        end
        pc = pc_in;
        chk("ack start", 16'h0001, {15'h0000, ack.start});
        chk("ack kind", {15'h0000, nmi}, {15'h0000, ack.nmi});
        if (!nmi) begin
            chk("ack source", {12'h000, s}, {12'h000, ack.source});
        end
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk("status push", {8'h01, st}, {7'h00, push_valid, push_data});
        @(negedge clk_sys);
        chk("pc high push", {8'h01, pc[15:8]}, {7'h00, push_valid, push_data});
        @(negedge clk_sys);
        chk("pc low push", {8'h01, pc[7:0]}, {7'h00, push_valid, push_data});
        @(negedge clk_sys);
        chk("vector valid", 16'h0001, {15'h0000, vector_valid});
        chk("vector address", v, vector_addr);
        lat = lat + 5;
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hung run short
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end

    // Main sequence of tests
    initial begin
        {reset_n, nmi_req, flag_reg_access, enable_irq_instr} = '0;
        {irq_off_instr, return_from_irq_instr, psw_wr, mask_wr, req_clr} = '0;
        {psw_wdata, mask_wdata, req_clr_bits, periph_req, ext_irq_pin} = '0;
        sfr = '0;
        comparator_irq = 1'h1;
        key_pin = 6'h3F;
        key_pin_is_output = 6'h00;
        instr_len = 4'h4;
        cyc(3);
        reset_n = 1'h1;
        rd(16'hFFEC, 8'h00);
        rd(16'hFFED, 8'h00);
        rd(16'hFFF5, 8'h00);
        chk("status", 16'h0002, {8'h00, program_status_word});
        chk("masks", 16'hFFFF, source_mask_flag);
        chk("requests", 16'h0000, source_request_flag);
        sfr_op(1'h1, 16'hFFEC, 8'hFF);
        rd(16'hFFEC, 8'hFC);
        sfr_op(1'h1, 16'hFFED, 8'hFF);
        rd(16'hFFED, 8'hC3);
        sfr_op(1'h1, 16'hFFF5, 8'hFF);
        rd(16'hFFF5, 8'h31);
        rd(16'hFFEE, 8'h00);
        pulse_ie(1'h0);
        chk("enable", 16'h0000, {15'h0000, global_irq_enable});
        @(negedge clk_sys);
        psw_wr = 1'h1;
        psw_wdata = 8'h02;
        @(negedge clk_sys);
        psw_wr = 1'h0;
        chk("enable", 16'h0001, {15'h0000, global_irq_enable});
        $display("test registers done");
        // Every edge code on pin 0, source kept masked
        for (int i = 0; i < 4; i++) begin
            code = i[1:0];
            sfr_op(1'h1, 16'hFFEC, {4'h0, code, 2'h0});
            clr_req(16'h0002);
            ext_irq_pin[0] = 1'h1;
            cyc(5);
            chk("rise", {15'h0, code[0]}, {15'h0, source_request_flag[1]});
            clr_req(16'h0002);
            ext_irq_pin[0] = 1'h0;
            cyc(5);
            chk("fall", {15'h0, code[1] ~^ code[0]},
                {15'h0, source_request_flag[1]});
        end
        $display("test edge select done");
        sfr_op(1'h1, 16'hFFF5, 8'h01);
        clr_req(16'h2000);
        chk("pull-ups", 16'h000F, {10'h000, key_pullup_en});
        key_pin_is_output = 6'h01;
        cyc(1);
        chk("pull-ups", 16'h000E, {10'h000, key_pullup_en});
        key_pin_is_output = 6'h00;
        key_pin[2] = 1'h0;
        cyc(5);
        chk("key", 16'h0001, {15'h0, source_request_flag[13]});
        clr_req(16'h2000);
        key_pin[3] = 1'h0;
        cyc(5);
        chk("key", 16'h0000, {15'h0, source_request_flag[13]});
        key_pin = 6'h2F;
        cyc(5);
        chk("key", 16'h0000, {15'h0, source_request_flag[13]});
        $display("test key return done");
        clr_req(16'hFFFF);
        flag_reg_access = 1'h1;
        pulse_req(16'h00A0);
        set_mask(16'hFF5F);
        cyc(20);
        chk("held", 16'h00A0, source_request_flag);
        flag_reg_access = 1'h0;
        take_ack(1'h0, 4'h5, 16'h000E, 8'h02);
        cyc(30);
        chk("pending", 16'h0080, source_request_flag);
        pulse_ie(1'h1);
        take_ack(1'h0, 4'h7, 16'h0012, 8'h02);
        pulse_ie(1'h1);
        pulse_req(16'h0020);
        take_ack(1'h0, 4'h5, 16'h000E, 8'h02);
        chk("latency", 16'h0001, {15'h0000, lat <= 19});
        $display("test maskable done");
        instr_len = 4'hA;
        pulse_ie(1'h1);
        flag_reg_access = 1'h1;
        pulse_req(16'h0080);
        nmi_req = 1'h1;
        cyc(6);
        flag_reg_access = 1'h0;
        take_ack(1'h1, 4'h0, 16'h0004, 8'h02);
        nmi_req = 1'h0;
        cyc(3);
        nmi_req = 1'h1;
        take_ack(1'h1, 4'h0, 16'h0004, 8'h00);
        $display("test non-maskable done");
        complete_run();
    end
endmodule
